/* rtl/host_decode_map.vh */
// Address map, region indices and control bit positions for the host decode block
`ifndef HOST_DECODE_MAP_VH
`define HOST_DECODE_MAP_VH

// Physical PIO window: bits 35:22 fixed, 21:20 match the id pins
`define SYS_WIN_HI    14'h005C
`define OFF_HI_ZERO   4'h0

// Region base offsets inside the 64K map
`define CHIP_BASE     17'h00008
`define DESC_BASE     17'h01000
`define MIRAM_BASE    17'h02000
`define MIRES_BASE    17'h03000
`define BIRAM_BASE    17'h04000
`define BTAB_BASE     17'h05000
`define BBUF_BASE     17'h07000
`define BBUF_IN       17'h07800
`define DRAM_BASE     17'h08000
`define DRAM_B_BASE   17'h08800
`define DRAM_C_BASE   17'h09000
`define DUNUSED_BASE  17'h09800
`define UNUSED_BASE   17'h0C000
`define KREG_BASE     17'h0E000
`define TLB_BASE      17'h0F000
`define MAP_TOP       17'h10000

// Region indices
`define RG_SAFE       0
`define RG_CHIP       1
`define RG_DESC       2
`define RG_MIRAM      3
`define RG_MIRES      4
`define RG_BIRAM      5
`define RG_BTAB       6
`define RG_BBUF       7
`define RG_DRAM       8
`define RG_DUNUSED    9
`define RG_UNUSED     10
`define RG_KREG       11
`define RG_TLB        12
`define RG_N          13

// Internal registers
`define PCS_OFF       16'h0010
`define PCS_HALT      0
`define PCS_GO        1
`define PCS_DMA_CLR   2
`define PERM_OFF      16'hE000
`define PERM_TLB_WE   0
`define PBASE_OFF     16'hE004

// Processor access kinds
`define ACC_LS        2'h0
`define ACC_COP1      2'h1
`define ACC_COPROCESSOR_THREE      2'h2
`define ACC_FETCH     2'h3

// DMA logical windows, bits 31:22
`define LIN_WIN       10'h002
`define TILE_WIN      10'h042
`define MAX_OUT       3'h4
`define PROC_HI_ZERO  16'h0000

`endif

/* rtl/region_decoder.v */
// One-hot region decode of a 16-bit chip offset
`include "host_decode_map.vh"
module region_decoder (
   // Offset in, regions out
   input  wire [15:0]        off,
   input  wire               in_map,
   output wire [`RG_N-1:0]   rg
);
   localparam [(`RG_N+1)*17-1:0] BOUNDS = {
      `MAP_TOP, `TLB_BASE, `KREG_BASE, `UNUSED_BASE, `DUNUSED_BASE,
      `DRAM_BASE, `BBUF_BASE, `BTAB_BASE, `BIRAM_BASE, `MIRES_BASE,
      `MIRAM_BASE, `DESC_BASE, `CHIP_BASE, 17'h00000};
   wire [16:0] off_w;
   assign off_w = {1'b0, off};
   genvar i;
   generate
      for (i = 0; i < `RG_N; i = i + 1) begin : g_rg
         assign rg[i] = in_map && (off_w >= BOUNDS[i*17 +: 17]) && (off_w < BOUNDS[(i+1)*17 +: 17]);
      end
   endgenerate
endmodule

/* rtl/translation_table.v */
// 64-entry page table mapping logical 64K pages to physical pages
module translation_table (
   // Clock
   input  wire       clock,
   // Write port
   input  wire       wr_en,
   input  wire [5:0] wr_idx,
   input  wire [5:0] wr_page,
   // Read ports
   input  wire [5:0] rd_idx_a,
   output wire [5:0] rd_page_a,
   input  wire [5:0] rd_idx_b,
   output wire [5:0] rd_page_b
);
   reg [5:0] pages [0:63];
   // Any logical page may point at any physical page, no adjacency needed
   always @(posedge clock) begin
      if (wr_en) begin
         pages[wr_idx] <= wr_page;
      end
   end
   assign rd_page_a = pages[rd_idx_a];
   assign rd_page_b = pages[rd_idx_b];
endmodule

/* rtl/host_address_decode_map.v */
// Host PIO decode, processor permissions and DMA window translation
// Behaviour
// - Claim PIO when bits 21:20 equal id
// - Id pins affect PIO decode only
// - Unimplemented in-window reads return zeros
// - DMA system access confined to 4MB
// - Registers and RAM host-mapped, register files not
// - All interrupt sources on one pin
// - Media processor halts on exception
// - Descriptor sets reached by coprocessor three moves
// - Chip registers reached by coprocessor one moves
// - Offsets 0-7 safe, no register
// - Buffers: bitstream ok, media excepts
// - Table memory bitstream only
// - Instruction RAM only host and DMA
// - Three data banks shared, rest excepts
// - Two logical windows, DMA only
// - Table write by DMA needs host permission
// - Out-of-range DMA address halts, interrupts
// - Processor loads never reach system memory
// - Each entry maps one 64K page
// - Win arbitration first, multiple outstanding reads
// - Host accesses device directly
`include "host_decode_map.vh"
module host_address_decode_map (
   // Clock and reset
   input  wire        clock,
   input  wire        srst,
   // Identity pins
   input  wire [1:0]  chip_select_id_pins,
   // Host PIO request
   input  wire        host_valid,
   input  wire        host_write,
   input  wire [35:0] host_addr,
   input  wire [31:0] host_wdata,
   output reg         host_claim_ff,
   output reg         host_drive_oe_ff,
   output reg         host_rvalid_ff,
   output reg  [31:0] host_rdata_ff,
   // Internal target strobes
   output reg  [12:0] tgt_sel_ff,
   output reg  [15:0] tgt_off_ff,
   output reg         tgt_write_ff,
   output reg  [31:0] tgt_wdata_ff,
   input  wire [31:0] tgt_rdata,
   // Media processor
   input  wire        media_valid,
   input  wire [1:0]  media_kind,
   input  wire [31:0] media_addr,
   input  wire        media_core_exc,
   output reg         media_grant_ff,
   output reg         media_exc_ff,
   output reg         media_halt_ff,
   // Bitstream processor
   input  wire        bsp_valid,
   input  wire [1:0]  bsp_kind,
   input  wire [31:0] bsp_addr,
   output reg         bsp_grant_ff,
   output reg         bsp_exc_ff,
   // DMA engine
   input  wire        dma_valid,
   input  wire        dma_write,
   input  wire [31:0] dma_laddr,
   input  wire        dma_tlb_we,
   input  wire [5:0]  dma_tlb_idx,
   input  wire [5:0]  dma_tlb_page,
   output reg         dma_busy_ff,
   output reg         dma_halt_ff,
   output reg         dma_tlb_refused_ff,
   // System bus master side
   input  wire        bus_grant_n,
   input  wire        sys_read_done,
   output reg         bus_request_n_ff,
   output reg         sys_valid_ff,
   output reg         sys_write_ff,
   output reg  [35:0] sys_addr_ff,
   // Interrupts
   input  wire [3:0]  int_src,
   output reg         irq_n_ff
);
   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_REQ  = 3'b010;
   localparam [2:0] S_ISS  = 3'b100;

   reg  [2:0]  state_ff;
   reg  [2:0]  out_cnt_ff;
   reg         h_rd_ff;
   reg  [12:0] h_rg_ff;
   reg         perm_ff;
   reg  [13:0] pbase_ff;
   reg         go_ff;
   reg         dma_wr_ff;

   wire [12:0] h_rg;
   wire [12:0] m_rg;
   wire [12:0] b_rg;
   wire        h_claim;
   wire        h_in_map;
   wire        h_pcs;
   wire        h_perm;
   wire        h_pbase;
   wire        h_tlb_wr;
   wire        h_pcs_wr;
   wire        d_tlb_ok;
   wire        tlb_we;
   wire [5:0]  tlb_widx;
   wire [5:0]  tlb_wpage;
   wire [5:0]  dma_page;
   wire [5:0]  host_page;
   wire        d_in_win;
   wire        m_ok;
   wire        b_ok;
   wire        issue;
   wire        ext_hit;

   // Window compare uses the id pins only here, never on arbitration lines
   assign h_claim  = host_valid && (host_addr[35:22] == `SYS_WIN_HI) &&
                     (host_addr[21:20] == chip_select_id_pins);
   assign h_in_map = host_addr[19:16] == `OFF_HI_ZERO;

   region_decoder u_host_dec (
      .off    (host_addr[15:0]),
      .in_map (h_in_map),
      .rg     (h_rg)
   );
   // Processor addresses above 64K include both system windows
   region_decoder u_media_dec (
      .off    (media_addr[15:0]),
      .in_map (media_addr[31:16] == `PROC_HI_ZERO),
      .rg     (m_rg)
   );
   region_decoder u_bsp_dec (
      .off    (bsp_addr[15:0]),
      .in_map (bsp_addr[31:16] == `PROC_HI_ZERO),
      .rg     (b_rg)
   );

   // Externally backed regions; reserved, unused and safe space stay zero
   assign ext_hit = h_rg[`RG_CHIP] | h_rg[`RG_DESC] | h_rg[`RG_MIRAM] | h_rg[`RG_BIRAM] |
                    h_rg[`RG_BTAB] | h_rg[`RG_BBUF] | h_rg[`RG_DRAM];
   assign h_pcs    = h_rg[`RG_CHIP] && (host_addr[15:0] == `PCS_OFF);
   assign h_perm   = h_rg[`RG_KREG] && (host_addr[15:0] == `PERM_OFF);
   assign h_pbase  = h_rg[`RG_KREG] && (host_addr[15:0] == `PBASE_OFF);
   assign h_tlb_wr = h_claim && host_write && h_rg[`RG_TLB];
   assign h_pcs_wr = h_claim && host_write && h_pcs;

   // Host write to the table wins; a DMA write needs the permission bit
   assign d_tlb_ok  = dma_tlb_we && perm_ff && !h_tlb_wr;
   assign tlb_we    = h_tlb_wr || d_tlb_ok;
   assign tlb_widx  = h_tlb_wr ? host_addr[7:2] : dma_tlb_idx;
   assign tlb_wpage = h_tlb_wr ? host_wdata[5:0] : dma_tlb_page;

   translation_table u_tlb (
      .clock     (clock),
      .wr_en     (tlb_we),
      .wr_idx    (tlb_widx),
      .wr_page   (tlb_wpage),
      .rd_idx_a  (dma_laddr[21:16]),
      .rd_page_a (dma_page),
      .rd_idx_b  (tgt_off_ff[7:2]),
      .rd_page_b (host_page)
   );

   // Only the two 4M logical windows translate
   assign d_in_win = (dma_laddr[31:22] == `LIN_WIN) || (dma_laddr[31:22] == `TILE_WIN);

   // Media: chip regs by cop1, descriptors by coprocessor_three, own IRAM fetch, data RAM
   assign m_ok = m_rg[`RG_SAFE] ||
                 (m_rg[`RG_CHIP] && media_kind == `ACC_COP1) ||
                 (m_rg[`RG_DESC] && media_kind == `ACC_COPROCESSOR_THREE) ||
                 (m_rg[`RG_MIRAM] && media_kind == `ACC_FETCH) ||
                 (m_rg[`RG_DRAM] && media_kind == `ACC_LS);
   // Bitstream: loads and stores across its regions, own IRAM fetch only
   assign b_ok = b_rg[`RG_SAFE] ||
                 ((b_rg[`RG_CHIP] | b_rg[`RG_DESC] | b_rg[`RG_BTAB] |
                   b_rg[`RG_BBUF] | b_rg[`RG_DRAM]) && bsp_kind == `ACC_LS) ||
                 (b_rg[`RG_BIRAM] && bsp_kind == `ACC_FETCH);

   assign issue = (state_ff == S_REQ) && !bus_grant_n &&
                  (dma_wr_ff || out_cnt_ff < `MAX_OUT);

   // Host stage one: claim and route
   always @(posedge clock) begin
      if (srst) begin
         host_claim_ff <= 1'b0;
         h_rd_ff       <= 1'b0;
         h_rg_ff       <= 13'h0000;
         tgt_sel_ff    <= 13'h0000;
         tgt_off_ff    <= 16'h0000;
         tgt_write_ff  <= 1'b0;
         tgt_wdata_ff  <= 32'h00000000;
      end else begin
         host_claim_ff <= h_claim;
         h_rd_ff       <= h_claim && !host_write;
         h_rg_ff       <= h_claim ? h_rg : 13'h0000;
         tgt_sel_ff    <= (h_claim && ext_hit && !h_pcs) ? h_rg : 13'h0000;
         tgt_off_ff    <= host_addr[15:0];
         tgt_write_ff  <= h_claim && host_write;
         tgt_wdata_ff  <= host_wdata;
      end
   end

   // Host stage two: read data, zeros where nothing is implemented
   always @(posedge clock) begin
      if (srst) begin
         host_rvalid_ff   <= 1'b0;
         host_drive_oe_ff <= 1'b0;
         host_rdata_ff    <= 32'h00000000;
      end else begin
         host_rvalid_ff   <= h_rd_ff;
         host_drive_oe_ff <= h_rd_ff;
         if (!h_rd_ff) begin
            host_rdata_ff <= 32'h00000000;
         end else if (|tgt_sel_ff) begin
            host_rdata_ff <= tgt_rdata;
         end else if (h_rg_ff[`RG_CHIP] && tgt_off_ff == `PCS_OFF) begin
            host_rdata_ff <= {29'h00000000, dma_halt_ff, go_ff, media_halt_ff};
         end else if (h_rg_ff[`RG_KREG] && tgt_off_ff == `PERM_OFF) begin
            host_rdata_ff <= {31'h00000000, perm_ff};
         end else if (h_rg_ff[`RG_KREG] && tgt_off_ff == `PBASE_OFF) begin
            host_rdata_ff <= {18'h00000, pbase_ff};
         end else if (h_rg_ff[`RG_TLB]) begin
            host_rdata_ff <= {26'h0000000, host_page};
         end else begin
            host_rdata_ff <= 32'h00000000;
         end
      end
   end

   // Host-owned control: permission, region base, processor control
   always @(posedge clock) begin
      if (srst) begin
         perm_ff  <= 1'b0;
         pbase_ff <= 14'h0000;
         go_ff    <= 1'b0;
      end else begin
         if (h_claim && host_write && h_perm) begin
            perm_ff <= host_wdata[`PERM_TLB_WE];
         end
         if (h_claim && host_write && h_pbase) begin
            pbase_ff <= host_wdata[13:0];
         end
         if (h_pcs_wr) begin
            go_ff <= host_wdata[`PCS_GO];
         end else if (media_halt_ff) begin
            go_ff <= 1'b0;
         end
      end
   end

   // Processor permission checks; a refused access is an address exception
   always @(posedge clock) begin
      if (srst) begin
         media_grant_ff <= 1'b0;
         media_exc_ff   <= 1'b0;
         media_halt_ff  <= 1'b0;
         bsp_grant_ff   <= 1'b0;
         bsp_exc_ff     <= 1'b0;
      end else begin
         media_grant_ff <= media_valid && !media_halt_ff && m_ok;
         media_exc_ff   <= media_valid && !media_halt_ff && !m_ok;
         bsp_grant_ff   <= bsp_valid && b_ok;
         bsp_exc_ff     <= bsp_valid && !b_ok;
         // A new exception outranks the host restart in the same cycle
         if ((media_valid && !m_ok) || media_core_exc || media_exc_ff) begin
            media_halt_ff <= 1'b1;
         end else if (h_pcs_wr) begin
            media_halt_ff <= host_wdata[`PCS_HALT] || !host_wdata[`PCS_GO];
         end
      end
   end

   // DMA path: range check, translate, arbitrate, issue
   always @(posedge clock) begin
      if (srst) begin
         state_ff         <= S_IDLE;
         dma_busy_ff      <= 1'b0;
         dma_halt_ff      <= 1'b0;
         dma_wr_ff        <= 1'b0;
         bus_request_n_ff <= 1'b1;
         sys_valid_ff     <= 1'b0;
         sys_write_ff     <= 1'b0;
         sys_addr_ff      <= 36'h000000000;
      end else begin
         if (h_pcs_wr && host_wdata[`PCS_DMA_CLR] && state_ff == S_IDLE && !dma_valid) begin
            dma_halt_ff <= 1'b0;
         end
         case (state_ff)
            S_IDLE: begin
               sys_valid_ff <= 1'b0;
               if (dma_valid && !dma_halt_ff) begin
                  if (d_in_win) begin
                     // Region base fixes the 4MB window, entry picks the 64K page
                     sys_addr_ff      <= {pbase_ff, dma_page, dma_laddr[15:0]};
                     sys_write_ff     <= dma_write;
                     dma_wr_ff        <= dma_write;
                     bus_request_n_ff <= 1'b0;
                     dma_busy_ff      <= 1'b1;
                     state_ff         <= S_REQ;
                  end else begin
                     dma_halt_ff <= 1'b1;
                  end
               end
            end
            S_REQ: begin
               if (issue) begin
                  sys_valid_ff     <= 1'b1;
                  bus_request_n_ff <= 1'b1;
                  state_ff         <= S_ISS;
               end
            end
            S_ISS: begin
               sys_valid_ff <= 1'b0;
               dma_busy_ff  <= 1'b0;
               state_ff     <= S_IDLE;
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   // Outstanding read count; a read may launch before earlier data returns
   always @(posedge clock) begin
      if (srst) begin
         out_cnt_ff <= 3'h0;
      end else if (issue && !dma_wr_ff && !sys_read_done) begin
         out_cnt_ff <= out_cnt_ff + 3'h1;
      end else if (!(issue && !dma_wr_ff) && sys_read_done && out_cnt_ff != 3'h0) begin
         out_cnt_ff <= out_cnt_ff - 3'h1;
      end
   end

   // Refusal flag and single interrupt pin
   always @(posedge clock) begin
      if (srst) begin
         dma_tlb_refused_ff <= 1'b0;
         irq_n_ff           <= 1'b1;
      end else begin
         dma_tlb_refused_ff <= dma_tlb_we && !d_tlb_ok;
         irq_n_ff           <= !((|int_src) || dma_halt_ff || media_halt_ff);
      end
   end
endmodule

/* verification/host_decode_checker_assertions.sv */
// Port-level checker for the host decode and permission block
`include "host_decode_map.vh"
module host_decode_checker (
   // Clock and reset
   input logic        clock,
   input logic        srst,
   // Host side
   input logic [1:0]  chip_select_id_pins,
   input logic        host_valid,
   input logic        host_write,
   input logic [35:0] host_addr,
   input logic        host_claim_ff,
   input logic        host_drive_oe_ff,
   input logic        host_rvalid_ff,
   input logic [31:0] host_rdata_ff,
   // Processors
   input logic        media_valid,
   input logic [1:0]  media_kind,
   input logic [31:0] media_addr,
   input logic        media_grant_ff,
   input logic        media_exc_ff,
   input logic        media_halt_ff,
   input logic        bsp_valid,
   input logic [1:0]  bsp_kind,
   input logic [31:0] bsp_addr,
   input logic        bsp_grant_ff,
   input logic        bsp_exc_ff,
   // DMA and system bus
   input logic        dma_valid,
   input logic [31:0] dma_laddr,
   input logic        dma_busy_ff,
   input logic        dma_halt_ff,
   input logic        bus_grant_n,
   input logic        bus_request_n_ff,
   input logic        sys_valid_ff,
   input logic [35:0] sys_addr_ff,
   // Interrupts
   input logic [3:0]  int_src,
   input logic        irq_n_ff
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (srst);
   wire pio_hit  = host_valid && host_addr[35:22] == 14'h005C && host_addr[21:20] == chip_select_id_pins;
   // Beyond the 64K map, or the unused 8K hole
   wire pio_void = host_addr[19:16] != 4'h0 || host_addr[15:13] == 3'h6;
   wire m_ls     = media_valid && !media_halt_ff && media_kind == `ACC_LS;
   wire b_ls     = bsp_valid && bsp_kind == `ACC_LS;
   wire d_take   = dma_valid && !dma_busy_ff && !dma_halt_ff;
   wire d_in     = dma_laddr[31:22] == `LIN_WIN || dma_laddr[31:22] == `TILE_WIN;
   logic [15:0] lo_ff;
   always @(posedge clock) begin
      if (d_take && d_in)
         lo_ff <= dma_laddr[15:0];
   end
   AST_PIO_CLAIM: assert property (pio_hit |=> host_claim_ff)
      else $error("window hit not claimed");
   AST_PIO_IGNORE: assert property (host_valid && host_addr[21:20] != chip_select_id_pins |=>
      !host_claim_ff ##1 !host_drive_oe_ff) else $error("foreign access answered");
   AST_READ_ZERO: assert property (pio_hit && !host_write && pio_void |=> ##1
      host_rvalid_ff && host_rdata_ff == 32'h0) else $error("void read not zero");
   AST_MEDIA_BUF: assert property (m_ls && media_addr[31:12] == 20'h00007 |=>
      media_exc_ff && media_halt_ff ##1 !irq_n_ff) else $error("media buffer access not stopped");
   AST_MEDIA_IRAM: assert property (m_ls && media_addr[31:13] == 19'h1 |=>
      media_exc_ff && !media_grant_ff) else $error("media load to code store allowed");
   AST_BSP_TABLE: assert property (b_ls && bsp_addr >= 32'h5000 && bsp_addr < 32'h8000 |=> bsp_grant_ff)
      else $error("bitstream table access refused");
   AST_PROC_SYS: assert property (b_ls && bsp_addr[31:16] != 16'h0 |=> bsp_exc_ff && !bsp_grant_ff)
      else $error("processor reached system range");
   AST_HALT_HOLD: assert property (!host_valid ##1 (media_halt_ff && !host_valid) |=> media_halt_ff)
      else $error("media halt dropped by itself");
   AST_DMA_RANGE: assert property (d_take && !d_in |=> dma_halt_ff && bus_request_n_ff ##1 !irq_n_ff)
      else $error("out of range dma not halted");
   AST_DMA_REQ: assert property (d_take && d_in |=> !bus_request_n_ff && dma_busy_ff)
      else $error("dma request missing");
   AST_SYS_GRANT: assert property (sys_valid_ff |-> !$past(bus_grant_n) && !$past(bus_request_n_ff)
      && bus_request_n_ff) else $error("bus cycle without grant");
   AST_SYS_PAGE: assert property (sys_valid_ff |-> sys_addr_ff[15:0] == lo_ff)
      else $error("page offset altered");
   AST_IRQ: assert property (|int_src |=> !irq_n_ff)
      else $error("interrupt source not shown");
endmodule

bind host_address_decode_map host_decode_checker checker_inst (.*);

/* verification/bus_arbiter_model.sv */
// Memory controller stand-in: grant and read completions for one chip
module bus_arbiter_model (
   // Clock and reset
   input  logic clock,
   input  logic srst,
   // Chip request side
   input  logic req_n,
   input  logic sys_valid,
   input  logic sys_write,
   input  logic slow,
   // Answers
   output logic grant_n,
   output logic read_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] wait_ff;
   logic       done_ff;
   initial begin
      grant_n   = 1'b1;
      read_done = 1'b0;
   end
   // One private request/grant pair per chip, so no sharing logic here
   always @(posedge clock) begin
      if (srst || req_n) begin
         wait_ff <= 3'h0;
         grant_n <= 1'b1;
      end else if (wait_ff == (slow ? 3'h3 : 3'h0)) begin
         grant_n <= 1'b0;
      end else begin
         wait_ff <= wait_ff + 3'h1;
      end
      done_ff   <= sys_valid && !sys_write && !srst;
      read_done <= done_ff;
   end
endmodule

/* verification/test_host_address_decode_map.sv */
// Self-checking bench for the host decode and permission block
`include "host_decode_map.vh"
module test_host_address_decode_map;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, srst, host_valid, host_write, media_valid, media_core_exc, bsp_valid, slow;
   logic        dma_valid, dma_write, dma_tlb_we, bus_grant_n, sys_read_done, host_claim_ff;
   logic        host_drive_oe_ff, host_rvalid_ff, tgt_write_ff, media_grant_ff, media_exc_ff, media_halt_ff;
   logic        bsp_grant_ff, bsp_exc_ff, dma_busy_ff, dma_halt_ff, dma_tlb_refused_ff, g_claim, g_oe, g_wr;
   logic        bus_request_n_ff, sys_valid_ff, sys_write_ff, irq_n_ff;
   logic [1:0]  chip_select_id_pins, media_kind, bsp_kind;
   logic [3:0]  int_src;
   logic [5:0]  dma_tlb_idx, dma_tlb_page;
   logic [12:0] tgt_sel_ff, g_sel;
   logic [15:0] tgt_off_ff;
   logic [31:0] host_wdata, tgt_rdata, media_addr, bsp_addr, dma_laddr, host_rdata_ff, tgt_wdata_ff, g_rd;
   logic [35:0] host_addr, sys_addr_ff;
   int          n_mismatch, num_checks, cyc;
   host_address_decode_map dut (.*);
   bus_arbiter_model far_end (.clock(clock), .srst(srst), .req_n(bus_request_n_ff), .sys_valid(sys_valid_ff),
      .sys_write(sys_write_ff), .slow(slow), .grant_n(bus_grant_n), .read_done(sys_read_done));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // A hang costs one mismatch and still reaches the verdict
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic tick;
      @(posedge clock);
      #1;
   endtask
   task automatic chk(input string name, input logic [63:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   function automatic logic [35:0] wa(input logic [19:0] off);
      return {14'h005C, chip_select_id_pins, off};
   endfunction
   task automatic host_op(input logic w, input logic [35:0] a, input logic [31:0] d);
      tick;
      {host_valid, host_write, host_addr, host_wdata} = {1'b1, w, a, d};
      tick;
      host_valid = 1'b0;
      g_claim = host_claim_ff;
      g_sel = tgt_sel_ff;
      g_wr = tgt_write_ff;
      tick;
      g_oe = host_drive_oe_ff;
      g_rd = host_rdata_ff;
   endtask
   task automatic test_id;
      for (int i = 0; i < 4; i++) begin
         chip_select_id_pins = i[1:0];
         host_op(1'b0, wa(20'h08000), 32'h0);
         chk("claim", {g_claim, g_wr, g_oe}, 3'h5);
         chk("rdata", g_rd, tgt_rdata);
         host_op(1'b0, {14'h005C, i[1:0] + 2'h1, 20'h08000}, 32'h0);
         chk("foreign", {g_claim, g_oe}, 2'h0);
      end
      chip_select_id_pins = 2'h2;
      $display("test id done");
   endtask
   task automatic void_read(input logic [19:0] off);
      host_op(1'b0, wa(off), 32'h0);
      chk("void", {g_sel, g_oe, g_rd}, {13'h0, 1'b1, 32'h0});
   endtask
   task automatic test_map;
      logic [15:0] offs [0:7];
      logic [3:0]  bits [0:7];
      offs = '{16'h0008, 16'h1000, 16'h2000, 16'h4000, 16'h5000, 16'h7000, 16'h8800, 16'h9000};
      bits = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h8};
      for (int i = 0; i < 8; i++) begin
         host_op(1'b1, wa({4'h0, offs[i]}), {16'h0, offs[i]});
         chk("region", g_sel, 13'h1 << bits[i]);
         chk("target", {g_wr, tgt_wdata_ff, tgt_off_ff}, {1'b1, 16'h0, offs[i], offs[i]});
      end
      void_read(20'h00004);
      void_read(20'h0C000);
      void_read(20'h10000);
      $display("test map done");
   endtask
   task automatic proc(input logic who, input logic [1:0] k, input logic [31:0] a, input logic e);
      tick;
      {media_valid, bsp_valid, media_kind, bsp_kind, media_addr, bsp_addr} = {!who, who, k, k, a, a};
      tick;
      {media_valid, bsp_valid} = 2'h0;
      chk("grant", who ? bsp_grant_ff : media_grant_ff, !e);
      chk("exc", who ? bsp_exc_ff : media_exc_ff, e);
      if (!who && e) begin
         chk("halt", media_halt_ff, 1'b1);
         tick;
         chk("irq", irq_n_ff, 1'b0);
         {media_valid, media_kind, media_addr} = {1'b1, `ACC_COP1, 32'h8};
         tick;
         media_valid = 1'b0;
         chk("halted", media_grant_ff, 1'b0);
         host_op(1'b1, wa(20'h00010), 32'h2);
         tick;
         chk("restart", {media_halt_ff, irq_n_ff}, 2'h1);
      end
   endtask
   task automatic test_proc;
      proc(1'b0, `ACC_COP1, 32'h0008, 1'b0);
      proc(1'b0, `ACC_COPROCESSOR_THREE, 32'h1000, 1'b0);
      proc(1'b0, `ACC_FETCH, 32'h2000, 1'b0);
      proc(1'b0, `ACC_LS, 32'h8800, 1'b0);
      proc(1'b0, `ACC_LS, 32'h0000, 1'b0);
      proc(1'b0, `ACC_LS, 32'h5000, 1'b1);
      proc(1'b0, `ACC_LS, 32'h7000, 1'b1);
      proc(1'b0, `ACC_LS, 32'h2000, 1'b1);
      proc(1'b0, `ACC_LS, 32'h9800, 1'b1);
      proc(1'b0, `ACC_LS, 32'h00800000, 1'b1);
      proc(1'b1, `ACC_LS, 32'h7800, 1'b0);
      proc(1'b1, `ACC_LS, 32'h5000, 1'b0);
      proc(1'b1, `ACC_LS, 32'h1000, 1'b0);
      proc(1'b1, `ACC_FETCH, 32'h4000, 1'b0);
      proc(1'b1, `ACC_LS, 32'h4000, 1'b1);
      proc(1'b1, `ACC_LS, 32'hE000, 1'b1);
      proc(1'b1, `ACC_LS, 32'h00800000, 1'b1);
      $display("test proc done");
   endtask
   task automatic dma_go(input logic w, input logic [31:0] la, input logic s, input logic [35:0] ea);
      int n;
      slow = s;
      tick;
      {dma_valid, dma_write, dma_laddr} = {1'b1, w, la};
      tick;
      dma_valid = 1'b0;
      chk("dma_req", {dma_busy_ff, bus_request_n_ff}, 2'h2);
      n = 0;
      while (sys_valid_ff !== 1'b1 && n < 20) begin
         tick;
         n++;
      end
      chk("sys", {sys_valid_ff, sys_write_ff, sys_addr_ff}, {1'b1, w, ea});
      tick;
      chk("dma_idle", dma_busy_ff, 1'b0);
   endtask
   task automatic test_dma;
      host_op(1'b1, wa(20'h0E004), 32'h123);
      host_op(1'b1, wa(20'h0F000), 32'h15);
      {dma_tlb_we, dma_tlb_idx, dma_tlb_page} = {1'b1, 6'h1, 6'h2A};
      tick;
      dma_tlb_we = 1'b0;
      chk("tlb_refused", dma_tlb_refused_ff, 1'b1);
      host_op(1'b1, wa(20'h0E000), 32'h1);
      dma_tlb_we = 1'b1;
      tick;
      dma_tlb_we = 1'b0;
      chk("tlb_taken", dma_tlb_refused_ff, 1'b0);
      dma_go(1'b0, 32'h00811234, 1'b1, {14'h0123, 6'h2A, 16'h1234});
      dma_go(1'b1, 32'h10800040, 1'b0, {14'h0123, 6'h15, 16'h0040});
      {dma_valid, dma_laddr} = {1'b1, 32'h00C00000};
      tick;
      dma_valid = 1'b0;
      chk("dma_halt", {dma_halt_ff, bus_request_n_ff}, 2'h3);
      {dma_valid, dma_laddr} = {1'b1, 32'h00811234};
      tick;
      dma_valid = 1'b0;
      chk("halted_dma", {irq_n_ff, dma_busy_ff, bus_request_n_ff}, 3'h1);
      host_op(1'b1, wa(20'h00010), 32'h6);
      tick;
      chk("dma_clear", {dma_halt_ff, irq_n_ff}, 2'h1);
      $display("test dma done");
   endtask
   task automatic test_irq;
      int_src = 4'h8;
      tick;
      chk("irq_on", irq_n_ff, 1'b0);
      int_src = 4'h0;
      tick;
      chk("irq_off", irq_n_ff, 1'b1);
      $display("test irq done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      srst = 1'b1;
      {host_valid, host_write, media_valid, media_core_exc, bsp_valid, dma_valid, dma_write, dma_tlb_we} = '0;
      {slow, chip_select_id_pins, media_kind, bsp_kind, host_addr, host_wdata, media_addr, bsp_addr} = '0;
      {dma_laddr, dma_tlb_idx, dma_tlb_page, int_src} = '0;
      tgt_rdata = 32'hC0DE0001;
      repeat (4) @(posedge clock);
      #1;
      srst = 1'b0;
      test_id();
      test_map();
      test_proc();
      test_dma();
      test_irq();
      results();
   end
endmodule
